// [testbench/cadr_top_checker.sv]
// Concurrent checks on the ports of the accessory detect register bank
`default_nettype none

module cadr_top_checker (
    // Clock and reset
    input wire logic                   clk_sys,
    input wire logic                   arst_n,
    // Register port
    input wire cadr_pkg::cadr_reg_req_t reg_req,
    input wire logic [15:0]            reg_rdata,
    input wire logic                   reg_rvalid,
    // Detector inputs
    input wire logic                   slow_clk_run,
    input wire logic                   left_jack_comp,
    input wire logic                   right_jack_comp,
    input wire logic                   mic_present_comp,
    input wire logic                   mic_short_comp,
    // Block outputs
    input wire cadr_pkg::cadr_ctrl_t   ctrl,
    input wire cadr_pkg::cadr_events_t events
);
    // ****************************************************************
    // Clocking and access steps
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    // Write or read strobe aimed at one register index
    sequence s_wr(a); reg_req.wr && reg_req.addr == a; endsequence
    sequence s_rd(a); reg_req.rd && reg_req.addr == a; endsequence

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_left_jack_write: assert property (
        s_wr(8'h4D) |=> ctrl.left_jack_sense_en == $past(reg_req.wdata[15]))
        else $error("Left jack enable not taken from bit 15");
    a_right_jack_write: assert property (
        s_wr(8'h4D) |=> ctrl.right_jack_sense_en == $past(reg_req.wdata[14]))
        else $error("Right jack enable not taken from bit 14");
    a_mic_en_power: assert property (
        s_wr(8'h08) |=> ctrl.mic_sense_en == $past(reg_req.wdata[8]))
        else $error("Mic enable not taken from power bit 8");
    a_mic_en_bias: assert property (
        s_wr(8'h4A) |=> ctrl.mic_sense_en == $past(reg_req.wdata[7]))
        else $error("Mic enable not taken from bias bit 7");
    a_plugin_thr_write: assert property (
        s_wr(8'h4A) |=> ctrl.plugin_current_threshold == $past(reg_req.wdata[4:2]))
        else $error("Plug-in threshold not taken from bits 4 to 2");
    a_short_thr_write: assert property (
        s_wr(8'h4A) |=> ctrl.short_current_threshold == $past(reg_req.wdata[1:0]))
        else $error("Short threshold not taken from bits 1 to 0");
    a_string_ctrl_write: assert property (
        s_wr(8'h08) |=> {ctrl.midrail_string_en, ctrl.midrail_select} == $past(reg_req.wdata[2:0]))
        else $error("Mid-rail string controls not taken from bits 2 to 0");
    a_sense_read_back: assert property (
        s_rd(8'h4D) |=> reg_rvalid && reg_rdata == {$past(ctrl.left_jack_sense_en),
            $past(ctrl.right_jack_sense_en), 14'h0000})
        else $error("Sense register read back wrong");
    a_sense_disabled: assert property (
        (!ctrl.left_jack_sense_en)[*2] |-> !events.left_jack_status && !events.left_jack_event)
        else $error("Disabled left jack detector still reports");
    a_mic_event_cause: assert property (
        events.mic_present_event |-> events.mic_present_status && $past(ctrl.mic_sense_en))
        else $error("Mic present event without enable or status");
    a_short_event_cause: assert property (
        events.mic_short_event |-> events.mic_short_status && $past(ctrl.mic_sense_en))
        else $error("Mic short event without enable or status");
    a_sync_depth: assert property (
        $rose(events.left_jack_status) |-> $past(left_jack_comp, 3))
        else $error("Left jack status rose ahead of the synchroniser");
    a_slow_clock_gate: assert property (
        (!slow_clk_run)[*2] |-> !(events.left_jack_event || events.right_jack_event
            || events.mic_present_event || events.mic_short_event))
        else $error("Detector event while the slow clock is stopped");
endmodule

bind cadr_top cadr_top_checker cadr_top_checker_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .slow_clk_run(slow_clk_run), .left_jack_comp(left_jack_comp),
    .right_jack_comp(right_jack_comp), .mic_present_comp(mic_present_comp),
    .mic_short_comp(mic_short_comp), .ctrl(ctrl), .events(events));

`default_nettype wire

// [testbench/cadr_top_tb.sv]
// Self-checking bench for the accessory detect register bank and detectors
`default_nettype none

module cadr_top_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // Signals and expected register state
    // ****************************************************************
    logic                    clk_sys;
    logic                    arst_n;
    cadr_pkg::cadr_reg_req_t reg_req;
    logic [15:0]             reg_rdata;
    logic                    reg_rvalid;
    logic                    slow_clk_run;
    logic [3:0]              comp;
    cadr_pkg::cadr_ctrl_t    ctrl;
    cadr_pkg::cadr_events_t  events;
    logic [15:0]             exp_q[$];
    int                      fail_count = 0;
    int                      checks_done = 0;
    int                      cyc = 0;
    logic                    lj, rj, mic, sen;
    logic [2:0]              pl;
    logic [1:0]              sel, sh;
    logic [15:0]             d;

    cadr_top cadr_top_i (.clk_sys(clk_sys), .arst_n(arst_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .slow_clk_run(slow_clk_run),
        .left_jack_comp(comp[3]), .right_jack_comp(comp[2]), .mic_present_comp(comp[1]),
        .mic_short_comp(comp[0]), .ctrl(ctrl), .events(events));

    // Free running system clock
    initial begin
        clk_sys = 1'h0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("Counts: %0d checks, %0d mismatches", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Read value the register map should give now; unused bits read 0
    function automatic logic [15:0] exp_rd(input logic [7:0] a);
        case (a)
            8'h08: return {7'h00, mic, 5'h00, sen, sel};
            8'h4A: return {8'h00, mic, 2'h0, pl, sh};
            8'h4D: return {lj, rj, 14'h0000};
            default: return 16'h0000;
        endcase
    endfunction

    // One register cycle; a read notes the old value before the write lands
    task automatic put(input logic w, input logic r, input logic [7:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        reg_req <= '{wr: w, rd: r, addr: a, wdata: v};
        if (r) exp_q.push_back(exp_rd(a));
        if (w && a == 8'h08) {mic, sen, sel} = {v[8], v[2:0]};
        if (w && a == 8'h4A) {mic, pl, sh} = {v[7], v[4:0]};
        if (w && a == 8'h4D) {lj, rj} = v[15:14];
        @(posedge clk_sys);
        reg_req <= '0;
    endtask

    // Reads every mapped index, one unmapped index, then the control outputs
    task automatic read_all();
        put(1'h0, 1'h1, 8'h08, 16'h0000);
        put(1'h0, 1'h1, 8'h4A, 16'h0000);
        put(1'h0, 1'h1, 8'h4D, 16'h0000);
        put(1'h0, 1'h1, 8'h33, 16'h0000);
        #1;
        check(16'(ctrl), {5'h00, lj, rj, mic, pl, sh, sen, sel});
    endtask

    // Raises then drops one comparator and counts the events each way
    task automatic pulse(input int i, input logic e);
        int hit;
        int nr;
        logic [7:0] ev;
        hit = 0;
        nr = 0;
        @(posedge clk_sys);
        comp[i] <= 1'h1;
        for (int k = 1; k <= 8; k++) begin
            @(posedge clk_sys);
            #1;
            ev = events;
            if (ev[i] === 1'h1 && hit == 0) hit = k;
            if (ev[i] === 1'h1) nr++;
        end
        check(16'(hit inside {[3:4]} && nr == 1), 16'(e));
        check(16'(ev[i+4]), 16'(e));
        nr = 0;
        @(posedge clk_sys);
        comp[i] <= 1'h0;
        repeat (8) begin
            @(posedge clk_sys);
            #1;
            ev = events;
            if (ev[i] === 1'h1) nr++;
        end
        check(16'(nr), 16'(e && i >= 2));
        check(16'(ev[i+4]), 16'h0000);
    endtask

    // ****************************************************************
    // Result watcher and hang guard
    // ****************************************************************
    always @(posedge clk_sys) begin
        if (reg_rvalid === 1'h1) begin
            check(reg_rdata, exp_q.pop_front());
        end
    end

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            complete_run();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(19603));
        {arst_n, slow_clk_run, comp, lj, rj, mic, sen, pl, sel, sh} = '0;
        reg_req = '0;
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'h1;
        slow_clk_run <= 1'h1;
        read_all();
        for (int i = 0; i < 4; i++) pulse(i, 1'h0);
        put(1'h1, 1'h0, 8'h4D, 16'hC000 | (16'($urandom) & 16'h3FFF));
        put(1'h1, 1'h0, 8'h08, 16'h0100);
        read_all();
        for (int i = 0; i < 4; i++) pulse(i, 1'h1);
        @(posedge clk_sys);
        slow_clk_run <= 1'h0;
        for (int i = 0; i < 4; i++) pulse(i, 1'h0);
        @(posedge clk_sys);
        slow_clk_run <= 1'h1;
        // Medium string while active, high resistance string for standby
        put(1'h1, 1'h0, 8'h08, 16'h0106);
        read_all();
        check(16'(ctrl.midrail_select), 16'(cadr_pkg::CADR_STRING_50K));
        put(1'h1, 1'h0, 8'h08, 16'h0105);
        read_all();
        check(16'(ctrl.midrail_select), 16'(cadr_pkg::CADR_STRING_300K));
        for (int c = 0; c < 8; c++) begin
            d = 16'($urandom);
            d[4:2] = 3'(c);
            d[1:0] = 2'(c);
            put(1'h1, 1'h0, 8'h4A, d);
            d = 16'($urandom);
            d[1:0] = 2'(c);
            put(1'h1, 1'h0, 8'h08, d);
            read_all();
        end
        put(1'h1, 1'h0, 8'h4C, 16'hFFFF);
        read_all();
        put(1'h1, 1'h1, 8'h4D, 16'h0000);
        read_all();
        // Second reset in mid-run brings every field back to its reset value
        @(posedge clk_sys);
        arst_n <= 1'h0;
        repeat (2) @(posedge clk_sys);
        {lj, rj, mic, sen, pl, sel, sh} = '0;
        arst_n <= 1'h1;
        read_all();
        repeat (4) @(posedge clk_sys);
        check(16'(exp_q.size()), 16'h0000);
        complete_run();
    end
endmodule

`default_nettype wire

// [verilog/cadr_pkg.sv]
// Package with register map, field layout and carrier types for accessory detect control
`default_nettype none

package cadr_pkg;

    // ****************************************************************
    // Register indices
    // ****************************************************************
    localparam logic [7:0] CADR_OFS_POWER_ONE   = 8'h08;
    localparam logic [7:0] CADR_OFS_MIC_BIAS    = 8'h4A;
    localparam logic [7:0] CADR_OFS_SENSE       = 8'h4D;

    // ****************************************************************
    // Field positions and widths
    // ****************************************************************
    localparam int CADR_DATA_W          = 16;
    localparam int CADR_ADDR_W          = 8;
    localparam int CADR_BIT_MIC_EN_PWR  = 8;
    localparam int CADR_BIT_MIC_EN_BIAS = 7;
    localparam int CADR_BIT_STRING_EN   = 2;
    localparam int CADR_SEL_LSB         = 0;
    localparam int CADR_SEL_W           = 2;
    localparam int CADR_PLUGIN_LSB      = 2;
    localparam int CADR_PLUGIN_W        = 3;
    localparam int CADR_SHORT_LSB       = 0;
    localparam int CADR_SHORT_W         = 2;
    localparam int CADR_BIT_LJACK       = 15;
    localparam int CADR_BIT_RJACK       = 14;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [1:0]  CADR_RST_SEL     = 2'h0;
    localparam logic [2:0]  CADR_RST_PLUGIN  = 3'h0;
    localparam logic [1:0]  CADR_RST_SHORT   = 2'h0;
    localparam logic        CADR_RST_BIT     = 1'h0;
    localparam logic [15:0] CADR_RST_WORD    = 16'h0000;

    // ****************************************************************
    // Reference string selection codes
    // ****************************************************************
    typedef enum logic [1:0] {
        CADR_STRING_OFF,
        CADR_STRING_300K,
        CADR_STRING_50K,
        CADR_STRING_5K
    } cadr_string_sel_t;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    // Register access request from the control interface
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } cadr_reg_req_t;

    // Analogue control settings driven out of the block
    typedef struct packed {
        logic             left_jack_sense_en;
        logic             right_jack_sense_en;
        logic             mic_sense_en;
        logic [2:0]       plugin_current_threshold;
        logic [1:0]       short_current_threshold;
        logic             midrail_string_en;
        cadr_string_sel_t midrail_select;
    } cadr_ctrl_t;

    // Detector results: status levels and one-cycle event pulses
    typedef struct packed {
        logic left_jack_status;
        logic right_jack_status;
        logic mic_present_status;
        logic mic_short_status;
        logic left_jack_event;
        logic right_jack_event;
        logic mic_present_event;
        logic mic_short_event;
    } cadr_events_t;

    // State of one comparator sense channel
    typedef struct packed {
        logic sync_first;
        logic sync_second;
        logic status;
        logic event_pulse;
    } cadr_sense_t;

    // State of the register bank
    typedef struct packed {
        cadr_ctrl_t  ctrl;
        logic [15:0] rdata;
        logic        rvalid;
    } cadr_bank_t;

endpackage

`default_nettype wire

// [verilog/cadr_sense_chan.sv]
// One comparator sense channel: two-flop synchroniser, enable gating and event pulse
`default_nettype none

module cadr_sense_chan #(
    parameter bit BOTH_EDGES = 1'h1
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic arst_n,
    // Controls
    input  wire logic sense_en,
    input  wire logic slow_clk_run,
    // Comparator in, results out
    input  wire logic comp_in,
    output logic      status,
    output logic      event_pulse
);

    cadr_pkg::cadr_sense_t st;
    cadr_pkg::cadr_sense_t next_st;
    logic                  active;
    logic                  changed;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st             = st;
        active              = sense_en && slow_clk_run;
        next_st.sync_first  = comp_in;
        next_st.sync_second = st.sync_first;
        changed             = BOTH_EDGES ? (st.sync_second != st.status)
                                         : (st.sync_second && !st.status);
        next_st.event_pulse = active && changed;
        if (!sense_en) begin
            next_st.status = 1'h0;
        end else if (slow_clk_run) begin
            next_st.status = st.sync_second;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign status      = st.status;
    assign event_pulse = st.event_pulse;

endmodule

`default_nettype wire

// [verilog/cadr_top.sv]
// Register bank and detectors for accessory sensing and mid-rail reference control
//
// Functional notes
// - Bit 15 of the sense control register enables jack sensing on the left second input.
// - Bit 14 of the sense control register enables jack sensing on the right second input.
// - With sensing on, each side reports its jack socket status through its own event.
// - Jack sensing runs only while the slow clock runs; software starts that clock first.
// - Bias current above the plug-in threshold marks a microphone present and raises its event.
// - Bias current above the short limit marks a short circuit and raises a separate event.
// - Microphone sensing runs only while the slow clock runs; software starts it first.
// - The microphone sense enable is one bit seen at power bit 8 and bias control bit 7.
// - Bias control bits 4 to 2 pick one of eight plug-in thresholds and reset to 000.
// - Bias control bits 1 to 0 pick one of four short limits and reset to 00.
// - Power register bit 2 enables the mid-rail resistor string and resets to 0.
// - Power register bits 1 to 0 pick off, 300k, 50k or 5k string and reset to 00.
`default_nettype none

module cadr_top (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  arst_n,
    // Register access port
    input  wire cadr_pkg::cadr_reg_req_t reg_req,
    output logic [15:0]                reg_rdata,
    output logic                       reg_rvalid,
    // Slow clock running indication
    input  wire logic                  slow_clk_run,
    // Analogue comparator outputs
    input  wire logic                  left_jack_comp,
    input  wire logic                  right_jack_comp,
    input  wire logic                  mic_present_comp,
    input  wire logic                  mic_short_comp,
    // Analogue control and detection results
    output var cadr_pkg::cadr_ctrl_t   ctrl,
    output var cadr_pkg::cadr_events_t events
);

    cadr_pkg::cadr_bank_t bank;
    cadr_pkg::cadr_bank_t next_bank;
    logic                 hit_power;
    logic                 hit_bias;
    logic                 hit_sense;
    logic                 left_status;
    logic                 left_event;
    logic                 right_status;
    logic                 right_event;
    logic                 mic_status;
    logic                 mic_event;
    logic                 short_status;
    logic                 short_event;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Address match for one register index
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
        addr_hit = (addr == ofs);
    endfunction

    // Read word for a register index; unused bits and unmapped indices read zero
    function automatic logic [15:0] read_word(input logic [7:0] addr,
                                              input cadr_pkg::cadr_ctrl_t c);
        logic [15:0] w;
        w = cadr_pkg::CADR_RST_WORD;
        if (addr_hit(addr, cadr_pkg::CADR_OFS_POWER_ONE)) begin
            w[cadr_pkg::CADR_BIT_MIC_EN_PWR] = c.mic_sense_en;
            w[cadr_pkg::CADR_BIT_STRING_EN]  = c.midrail_string_en;
            w[cadr_pkg::CADR_SEL_LSB +: cadr_pkg::CADR_SEL_W] = c.midrail_select;
        end else if (addr_hit(addr, cadr_pkg::CADR_OFS_MIC_BIAS)) begin
            w[cadr_pkg::CADR_BIT_MIC_EN_BIAS] = c.mic_sense_en;
            w[cadr_pkg::CADR_PLUGIN_LSB +: cadr_pkg::CADR_PLUGIN_W] =
                c.plugin_current_threshold;
            w[cadr_pkg::CADR_SHORT_LSB +: cadr_pkg::CADR_SHORT_W] =
                c.short_current_threshold;
        end else if (addr_hit(addr, cadr_pkg::CADR_OFS_SENSE)) begin
            w[cadr_pkg::CADR_BIT_LJACK] = c.left_jack_sense_en;
            w[cadr_pkg::CADR_BIT_RJACK] = c.right_jack_sense_en;
        end
        read_word = w;
    endfunction

    // ****************************************************************
    // Register writes and read capture
    // ****************************************************************
    always_comb begin
        next_bank  = bank;
        hit_power  = addr_hit(reg_req.addr, cadr_pkg::CADR_OFS_POWER_ONE);
        hit_bias   = addr_hit(reg_req.addr, cadr_pkg::CADR_OFS_MIC_BIAS);
        hit_sense  = addr_hit(reg_req.addr, cadr_pkg::CADR_OFS_SENSE);
        // Power management: mic sense enable, string enable and select
        if (reg_req.wr && hit_power) begin
            next_bank.ctrl.mic_sense_en =
                reg_req.wdata[cadr_pkg::CADR_BIT_MIC_EN_PWR];
            next_bank.ctrl.midrail_string_en =
                reg_req.wdata[cadr_pkg::CADR_BIT_STRING_EN];
            next_bank.ctrl.midrail_select = cadr_pkg::cadr_string_sel_t'(
                reg_req.wdata[cadr_pkg::CADR_SEL_LSB +: cadr_pkg::CADR_SEL_W]);
        end
        // Bias control: same mic sense enable plus both thresholds
        if (reg_req.wr && hit_bias) begin
            next_bank.ctrl.mic_sense_en =
                reg_req.wdata[cadr_pkg::CADR_BIT_MIC_EN_BIAS];
            next_bank.ctrl.plugin_current_threshold =
                reg_req.wdata[cadr_pkg::CADR_PLUGIN_LSB +: cadr_pkg::CADR_PLUGIN_W];
            next_bank.ctrl.short_current_threshold =
                reg_req.wdata[cadr_pkg::CADR_SHORT_LSB +: cadr_pkg::CADR_SHORT_W];
        end
        // Sense control: jack sense enables
        if (reg_req.wr && hit_sense) begin
            next_bank.ctrl.left_jack_sense_en =
                reg_req.wdata[cadr_pkg::CADR_BIT_LJACK];
            next_bank.ctrl.right_jack_sense_en =
                reg_req.wdata[cadr_pkg::CADR_BIT_RJACK];
        end
        // Read data captured from the current contents
        next_bank.rvalid = reg_req.rd;
        if (reg_req.rd) begin
            next_bank.rdata = read_word(reg_req.addr, bank.ctrl);
        end
    end

    // ****************************************************************
    // Bank register
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bank.ctrl.left_jack_sense_en       <= cadr_pkg::CADR_RST_BIT;
            bank.ctrl.right_jack_sense_en      <= cadr_pkg::CADR_RST_BIT;
            bank.ctrl.mic_sense_en             <= cadr_pkg::CADR_RST_BIT;
            bank.ctrl.plugin_current_threshold <= cadr_pkg::CADR_RST_PLUGIN;
            bank.ctrl.short_current_threshold  <= cadr_pkg::CADR_RST_SHORT;
            bank.ctrl.midrail_string_en        <= cadr_pkg::CADR_RST_BIT;
            bank.ctrl.midrail_select           <= cadr_pkg::CADR_STRING_OFF;
            bank.rdata                         <= cadr_pkg::CADR_RST_WORD;
            bank.rvalid                        <= 1'h0;
        end else begin
            bank <= next_bank;
        end
    end

    assign ctrl       = bank.ctrl;
    assign reg_rdata  = bank.rdata;
    assign reg_rvalid = bank.rvalid;

    // ****************************************************************
    // Detector channels
    // ****************************************************************
    // Jack channels report socket status, so both edges raise an event
    cadr_sense_chan #(.BOTH_EDGES(1'h1)) u_left_jack (
        .clk_sys      (clk_sys),
        .arst_n       (arst_n),
        .sense_en     (bank.ctrl.left_jack_sense_en),
        .slow_clk_run (slow_clk_run),
        .comp_in      (left_jack_comp),
        .status       (left_status),
        .event_pulse  (left_event)
    );

    cadr_sense_chan #(.BOTH_EDGES(1'h1)) u_right_jack (
        .clk_sys      (clk_sys),
        .arst_n       (arst_n),
        .sense_en     (bank.ctrl.right_jack_sense_en),
        .slow_clk_run (slow_clk_run),
        .comp_in      (right_jack_comp),
        .status       (right_status),
        .event_pulse  (right_event)
    );

    // Microphone channels raise an event when the current rises above threshold
    cadr_sense_chan #(.BOTH_EDGES(1'h0)) u_mic_present (
        .clk_sys      (clk_sys),
        .arst_n       (arst_n),
        .sense_en     (bank.ctrl.mic_sense_en),
        .slow_clk_run (slow_clk_run),
        .comp_in      (mic_present_comp),
        .status       (mic_status),
        .event_pulse  (mic_event)
    );

    cadr_sense_chan #(.BOTH_EDGES(1'h0)) u_mic_short (
        .clk_sys      (clk_sys),
        .arst_n       (arst_n),
        .sense_en     (bank.ctrl.mic_sense_en),
        .slow_clk_run (slow_clk_run),
        .comp_in      (mic_short_comp),
        .status       (short_status),
        .event_pulse  (short_event)
    );

    // Detector results gathered into one carrier, levels above pulses
    assign events = {left_status, right_status, mic_status, short_status,
                     left_event, right_event, mic_event, short_event};

endmodule

`default_nettype wire
